// *** pll_clock_synth_control.v ***
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "pll_clock_synth_control_regs.vh"

module pll_clock_synth_control #(
  parameter LOCK_PFD    = 16,
  parameter REF_TIMEOUT = 1024,
  parameter NOUT        = 5
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  ref_clock_in,
  input  wire [1:0]  ref_clock_select,
  input  wire        synth_reset_n,
  input  wire        core_feedback_in,
  input  wire        io_feedback_in,
  input  wire [2:0]  phase_shift,
  input  wire [4:0]  phase_out_select,
  input  wire        phase_apply_enable,
  output wire        out_clock_0,
  output wire        out_clock_1,
  output wire        out_clock_2,
  output wire        out_clock_3,
  output wire        out_clock_4,
  output reg         lock_indication,
  output reg         irq
);

  localparam ST_RESET   = 2'b00;
  localparam ST_ACQUIRE = 2'b01;
  localparam ST_LOCK_INDICATION  = 2'b10;
  localparam integer RST_MIN_CYC  = `SYNTH_RST_MIN_CYC;
  localparam [15:0] LOCK_PFD_W    = LOCK_PFD[15:0];
  localparam [15:0] REF_TIMEOUT_W = REF_TIMEOUT[15:0];
  localparam [3:0]  RST_MIN_W     = RST_MIN_CYC[3:0];

  reg  [31:0] div_reg;
  reg  [31:0] outdiv_reg;
  reg  [9:0]  outdiv4_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [3:0]  rst_low_reg;
  reg         ref_prev_reg;
  reg         fb_prev_reg;
  reg         fb_seen_reg;
  reg  [15:0] idle_reg;
  reg  [7:0]  pfd_cnt_reg;
  reg  [15:0] lock_cnt_reg;
  reg  [15:0] lock_cnt_next;
  reg  [16:0] credit_reg;
  reg         cfg_err_reg;
  wire [NOUT-1:0] out_vec;
  wire [3*NOUT-1:0] shift_all;

  wire [7:0]  div_n   = div_reg[`DIV_N_LSB +: 8];
  wire [7:0]  div_m   = div_reg[`DIV_M_LSB +: 8];
  wire [7:0]  div_o   = div_reg[`DIV_O_LSB +: 8];
  wire [7:0]  div_fbk = div_reg[`DIV_FBK_LSB +: 8];
  wire [1:0]  fb_mode = outdiv4_reg[`OUTDIV4_FB_LSB +: 2];
  wire [39:0] c_all   = {outdiv4_reg[7:0], outdiv_reg};

  // Loop product check; a bad setting keeps the loop from locking
  wire [23:0] loop_product = div_m * div_o * div_fbk;
  wire        cfg_bad = (div_n == 8'h00) || (div_m == 8'h00) || (div_o == 8'h00) ||
                        (div_fbk == 8'h00) || (loop_product > `LOOP_PRODUCT_MAX);

  // Selection follows the pins live; the testbench keeps reset low meanwhile
  wire ref_now  = ref_clock_in[ref_clock_select];
  wire ref_edge = ref_now & ~ref_prev_reg;
  wire fb_now   = (fb_mode == `FB_CORE) ? core_feedback_in :
                  (fb_mode == `FB_IO) ? io_feedback_in : 1'b0;
  wire fb_edge  = fb_now & ~fb_prev_reg;
  wire fb_used  = (fb_mode == `FB_CORE) || (fb_mode == `FB_IO);

  // Reset counted in cycles, so a pulse is honoured only if a clock edge samples it low
  wire in_reset = (rst_low_reg >= RST_MIN_W);

  // At or above the limit, so a smaller pre-divider takes effect at once
  wire pfd_tick = ref_edge && (pfd_cnt_reg >= div_n - 8'h01);
  wire fb_miss  = pfd_tick && fb_used && !fb_seen_reg && !fb_edge;
  wire ref_lost = (idle_reg == REF_TIMEOUT_W);

  // Half-cycle ticks of the post-divider clock, at most one per pclk
  wire [15:0] mf_product = div_m * div_fbk;
  wire [16:0] credit_add = ref_edge ? {mf_product, 1'b0} : 17'h00000;
  wire [16:0] credit_sum = credit_reg + credit_add;
  wire        half_tick  = (state_reg != ST_RESET) && !cfg_err_reg &&
                           (div_n != 8'h00) && (credit_sum >= {9'h000, div_n});

  wire bus_access = psel && penable && pready;
  wire bus_write  = bus_access && pwrite;
  wire bus_read   = bus_access && !pwrite;

  // Synthesizer reset filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_low_reg <= 4'h0;
    end else if (synth_reset_n) begin
      rst_low_reg <= 4'h0;
    end else if (rst_low_reg != 4'hF) begin
      rst_low_reg <= rst_low_reg + 4'h1;
    end
  end

  // Edge samplers, reference idle watchdog and phase detector divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_reg <= 1'b0;
      fb_prev_reg  <= 1'b0;
      fb_seen_reg  <= 1'b0;
      idle_reg     <= 16'h0000;
      pfd_cnt_reg  <= 8'h00;
      credit_reg   <= 17'h00000;
      cfg_err_reg  <= 1'b0;
    end else begin
      ref_prev_reg <= ref_now;
      fb_prev_reg  <= fb_now;
      cfg_err_reg  <= cfg_bad;
      if (in_reset || ref_edge) begin
        idle_reg <= 16'h0000;
      end else if (!ref_lost) begin
        idle_reg <= idle_reg + 16'h0001;
      end
      if (in_reset) begin
        pfd_cnt_reg <= 8'h00;
      end else if (pfd_tick) begin
        pfd_cnt_reg <= 8'h00;
      end else if (ref_edge) begin
        pfd_cnt_reg <= pfd_cnt_reg + 8'h01;
      end
      if (in_reset || pfd_tick) begin
        fb_seen_reg <= 1'b0;
      end else if (fb_edge) begin
        fb_seen_reg <= 1'b1;
      end
      if (in_reset || cfg_err_reg) begin
        credit_reg <= 17'h00000;
      end else if (half_tick) begin
        credit_reg <= credit_sum - {9'h000, div_n};
      end else if (credit_sum[16]) begin
        credit_reg <= 17'h0FFFF;
      end else begin
        credit_reg <= credit_sum;
      end
    end
  end

  // Lock state machine
  always @* begin
    state_next    = state_reg;
    lock_cnt_next = lock_cnt_reg;
    case (state_reg)
      ST_RESET: begin
        lock_cnt_next = 16'h0000;
        if (!in_reset) begin
          state_next = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (ref_lost || cfg_err_reg || fb_miss) begin
          lock_cnt_next = 16'h0000;
        end else if (pfd_tick) begin
          lock_cnt_next = lock_cnt_reg + 16'h0001;
          if (lock_cnt_next >= LOCK_PFD_W) begin
            state_next = ST_LOCK_INDICATION;
          end
        end
      end
      ST_LOCK_INDICATION: begin
        if (ref_lost || cfg_err_reg || fb_miss) begin
          state_next    = ST_ACQUIRE;
          lock_cnt_next = 16'h0000;
        end
      end
      default: begin
        state_next    = ST_RESET;
        lock_cnt_next = 16'h0000;
      end
    endcase
    if (in_reset) begin
      state_next    = ST_RESET;
      lock_cnt_next = 16'h0000;
    end
  end

  wire lock_gain_ev = (state_next == ST_LOCK_INDICATION) && (state_reg != ST_LOCK_INDICATION);
  wire lock_lost_ev = (state_reg == ST_LOCK_INDICATION) && (state_next != ST_LOCK_INDICATION);
  wire cfg_err_ev   = cfg_bad && !cfg_err_reg;
  wire [2:0] ev_vec = {cfg_err_ev, lock_lost_ev, lock_gain_ev};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_RESET;
      lock_cnt_reg    <= 16'h0000;
      lock_indication <= 1'b0;
    end else begin
      state_reg       <= state_next;
      lock_cnt_reg    <= lock_cnt_next;
      lock_indication <= (state_next == ST_LOCK_INDICATION);
    end
  end

  // Output dividers with per-output phase offset in half cycles
  genvar k;
  generate
    for (k = 0; k < NOUT; k = k + 1) begin : g_out
      reg  [8:0] cnt_reg;
      reg  [2:0] shift_reg;
      reg        out_reg;
      wire [7:0] c_val   = c_all[8*k +: 8];
      wire [8:0] period2 = {c_val, 1'b0};
      wire [8:0] adj     = (cnt_reg >= {6'h00, shift_reg}) ?
                           (cnt_reg - {6'h00, shift_reg}) :
                           (cnt_reg + period2 - {6'h00, shift_reg});
      assign shift_all[3*k +: 3] = shift_reg;
      assign out_vec[k]          = out_reg;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shift_reg <= 3'h0;
        end else if (phase_apply_enable && phase_out_select[k]) begin
          shift_reg <= phase_shift;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= 9'h000;
          out_reg <= 1'b0;
        end else if (in_reset || c_val == 8'h00) begin
          cnt_reg <= 9'h000;
          out_reg <= 1'b0;
        end else begin
          if (half_tick) begin
            cnt_reg <= (cnt_reg + 9'h001 >= period2) ? 9'h000 : cnt_reg + 9'h001;
          end
          // High for C half-ticks of each 2C, shifted by the stored code
          out_reg <= (adj < {1'b0, c_val});
        end
      end
    end
  endgenerate

  assign out_clock_0 = out_vec[0];
  assign out_clock_1 = out_vec[1];
  assign out_clock_2 = out_vec[2];
  assign out_clock_3 = out_vec[3];
  assign out_clock_4 = out_vec[4];

  // APB slave: one wait state, pready from a flop
  reg [31:0] rdata_next;
  reg        addr_ok;
  always @* begin
    rdata_next = 32'h00000000;
    addr_ok    = 1'b1;
    case (paddr)
      `DIV_REG_ADDR:     rdata_next = div_reg;
      `OUTDIV_REG_ADDR:  rdata_next = outdiv_reg;
      `OUTDIV4_REG_ADDR: rdata_next = {22'h00000, outdiv4_reg};
      `STATUS_REG_ADDR:  rdata_next = {27'h000000, ref_clock_select, cfg_err_reg,
                                       (state_reg == ST_RESET), lock_indication};
      `IRQ_STAT_ADDR:    rdata_next = {29'h0000000, irq_stat_reg};
      `IRQ_MASK_ADDR:    rdata_next = {29'h0000000, irq_mask_reg};
      `PHASE_REG_ADDR:   rdata_next = {{(32-3*NOUT){1'b0}}, shift_all};
      default:           addr_ok    = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= pwrite ? 32'h00000000 : rdata_next;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg      <= `DIV_RESET;
      outdiv_reg   <= `OUTDIV_RESET;
      outdiv4_reg  <= `OUTDIV4_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
    end else if (bus_write) begin
      case (paddr)
        `DIV_REG_ADDR:     div_reg      <= pwdata;
        `OUTDIV_REG_ADDR:  outdiv_reg   <= pwdata;
        `OUTDIV4_REG_ADDR: outdiv4_reg  <= pwdata[9:0];
        `IRQ_MASK_ADDR:    irq_mask_reg <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Read clears only the bits it returned, so an event that arrived while
  // the read was in flight is kept; an event in the clearing cycle wins too
  wire       stat_rd       = bus_read && (paddr == `IRQ_STAT_ADDR);
  wire [2:0] stat_clr      = stat_rd ? prdata[2:0] : 3'h0;
  wire [2:0] irq_stat_next = (irq_stat_reg & ~stat_clr) | ev_vec;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_next & irq_mask_reg);
    end
  end

endmodule // pll_clock_synth_control

// *** pll_clock_synth_control_regs.vh ***
`ifndef PLL_CLOCK_SYNTH_CONTROL_REGS_VH
`define PLL_CLOCK_SYNTH_CONTROL_REGS_VH

// Register byte offsets
`define DIV_REG_ADDR      8'h00
`define OUTDIV_REG_ADDR   8'h04
`define OUTDIV4_REG_ADDR  8'h08
`define STATUS_REG_ADDR   8'h0C
`define IRQ_STAT_ADDR     8'h10
`define IRQ_MASK_ADDR     8'h14
`define PHASE_REG_ADDR    8'h18

// Divider register fields
`define DIV_N_LSB         0
`define DIV_M_LSB         8
`define DIV_O_LSB         16
`define DIV_FBK_LSB       24
`define OUTDIV4_FB_LSB    8

// Reset values
`define DIV_RESET         32'h01010101
`define OUTDIV_RESET      32'h04040404
`define OUTDIV4_RESET     10'h004
`define IRQ_MASK_RESET    3'h0

// Feedback modes
`define FB_LOCAL          2'h0
`define FB_CORE           2'h1
`define FB_IO             2'h2

// Interrupt status bits
`define IRQ_LOCK_GAINED   0
`define IRQ_LOCK_LOST     1
`define IRQ_CFG_ERROR     2

// Loop product limit
`define LOOP_PRODUCT_MAX  24'h0000FF

// Least synthesizer reset pulse
`define SYNTH_RST_MIN_NS  10
`define PCLK_PERIOD_NS    100
`define SYNTH_RST_MIN_CYC \
  ((`SYNTH_RST_MIN_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

// *** pll_clock_synth_control_asserts.sv ***
`timescale 1ns/1ns
module pll_clock_synth_control_asserts #(
  parameter LOCK_PFD    = 16,
  parameter REF_TIMEOUT = 1024
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        synth_reset_n,
  input wire        out_clock_0,
  input wire        out_clock_1,
  input wire        lock_indication
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  chk_lock_reset: assert property (!synth_reset_n |-> ##2 !lock_indication)
    else $error("lock during reset");
  chk_relock_wait: assert property ($rose(synth_reset_n) |-> !lock_indication [*3])
    else $error("lock too early");
  chk_lock_rise: assert property ($rose(lock_indication) |-> $past(synth_reset_n, 2))
    else $error("lock rose from reset");
  chk_outs_held: assert property (!synth_reset_n [*3] |-> !out_clock_0 && !out_clock_1)
    else $error("outputs run in reset");
endmodule // pll_clock_synth_control_asserts

// *** ref_fabric_model.sv ***
`timescale 1ns/1ns
module ref_fabric_model #(
  parameter REF_HALF = 4
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       out_clock_0,
  input  wire       out_clock_1,
  output reg  [3:0] ref_clock_in,
  output wire       core_feedback_in,
  output wire       io_feedback_in
);
  reg [7:0] half_cnt;
  // Reference three never toggles, so selecting it starves the loop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt     <= 8'h00;
      ref_clock_in <= 4'h0;
    end else if (half_cnt == REF_HALF - 1) begin
      half_cnt     <= 8'h00;
      ref_clock_in <= {1'b0, ~ref_clock_in[2:0]};
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end
  // One synthesizer only, nothing cascaded behind it
  assign core_feedback_in = out_clock_0;
  assign io_feedback_in   = out_clock_1;
endmodule // ref_fabric_model

// *** tb_pll_clock_synth_control.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_pll_clock_synth_control;
  localparam REFP = 8;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [3:0]  ref_clock_in;
  reg  [1:0]  ref_clock_select = 2'h0;
  reg         synth_reset_n = 1'b0;
  wire        core_feedback_in;
  wire        io_feedback_in;
  reg  [2:0]  phase_shift = 3'h0;
  reg  [4:0]  phase_out_select = 5'h00;
  reg         phase_apply_enable = 1'b0;
  wire [4:0]  out_clk;
  wire        lock_indication;
  wire        irq;
  reg  [31:0] rd;
  reg         er;
  int         err_count = 0;
  int         n_checks = 0;
  int         i;
  always #50 pclk = ~pclk;
  pll_clock_synth_control #(.LOCK_PFD(2), .REF_TIMEOUT(32)) pll_clock_synth_control_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clock_in(ref_clock_in), .ref_clock_select(ref_clock_select),
    .synth_reset_n(synth_reset_n), .core_feedback_in(core_feedback_in),
    .io_feedback_in(io_feedback_in), .phase_shift(phase_shift),
    .phase_out_select(phase_out_select), .phase_apply_enable(phase_apply_enable),
    .out_clock_0(out_clk[0]), .out_clock_1(out_clk[1]), .out_clock_2(out_clk[2]),
    .out_clock_3(out_clk[3]), .out_clock_4(out_clk[4]),
    .lock_indication(lock_indication), .irq(irq));
  ref_fabric_model #(.REF_HALF(REFP / 2)) ref_fabric_model_inst (
    .pclk(pclk), .presetn(presetn), .out_clock_0(out_clk[0]), .out_clock_1(out_clk[1]),
    .ref_clock_in(ref_clock_in), .core_feedback_in(core_feedback_in),
    .io_feedback_in(io_feedback_in));
  task automatic apb(input [7:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input [7:0] a, input [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK("prdata", e, rd)
  endtask
  task automatic wait_lock(input logic e, input int lim);
    int t;
    t = 0;
    while (lock_indication !== e && t < lim) begin
      @(posedge pclk);
      t++;
    end
    `CHK("lock", e, lock_indication)
  endtask
  task automatic period(input int k, input int e);
    int c;
    repeat (2) begin
      c = 0;
      while (out_clk[k] === 1'b1) begin
        @(posedge pclk);
        c++;
      end
      while (out_clk[k] !== 1'b1) begin
        @(posedge pclk);
        c++;
      end
    end
    `CHK("period", e, c)
  endtask
  task automatic lag(input int e);
    int c;
    c = 0;
    while (out_clk[0] === 1'b1) @(posedge pclk);
    while (out_clk[0] !== 1'b1) @(posedge pclk);
    while (out_clk[2] !== 1'b1) begin
      @(posedge pclk);
      c++;
    end
    `CHK("lag", e, c)
  endtask
  task automatic phs(input [2:0] c, input [4:0] s, input en, input [31:0] e);
    phase_shift <= c;
    phase_out_select <= s;
    phase_apply_enable <= en;
    @(posedge pclk);
    phase_apply_enable <= 1'b0;
    rdc(8'h18, e);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h01010101);
    rdc(8'h04, 32'h04040404);
    rdc(8'h08, 32'h00000004);
    rdc(8'h14, 32'h00000000);
    apb(8'h1C, 1'b0, 32'h0);
    `CHK("pslverr", 1'b1, er)
    $display("test registers done");
    for (i = 0; i < 5; i++) begin
      synth_reset_n <= 1'b0;
      @(posedge pclk);
      ref_clock_select <= i[1:0];
      repeat (2 * REFP) @(posedge pclk);
      `CHK("lock_rst", 1'b0, lock_indication)
      synth_reset_n <= 1'b1;
      if (i != 3) wait_lock(1'b1, 200);
      else begin
        repeat (200) @(posedge pclk);
        `CHK("lock_dead", 1'b0, lock_indication)
      end
      if (i == 0) begin
        `CHK("irq_masked", 1'b0, irq)
        apb(8'h14, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq_set", 1'b1, irq)
        rdc(8'h10, 32'h00000001);
        @(posedge pclk);
        `CHK("irq_clear", 1'b0, irq)
        period(0, 4 * REFP);
        apb(8'h04, 1'b1, 32'h04040604);
        period(1, 6 * REFP);
      end
    end
    $display("test lock done");
    phs(3'h7, 5'h1F, 1'b1, 32'h00007FFF);
    phs(3'h0, 5'h1F, 1'b1, 32'h00000000);
    phs(3'h5, 5'h04, 1'b1, 32'h00000140);
    phs(3'h3, 5'h04, 1'b0, 32'h00000140);
    phs(3'h4, 5'h04, 1'b1, 32'h00000100);
    lag(2 * REFP);
    $display("test phase done");
    apb(8'h00, 1'b1, 32'h01101001);
    wait_lock(1'b0, 50);
    rdc(8'h0C, 32'h00000004);
    rdc(8'h10, 32'h00000007);
    apb(8'h00, 1'b1, 32'h01010101);
    wait_lock(1'b1, 200);
    $display("test config done");
    apb(8'h08, 1'b1, 32'h00000104);
    wait_lock(1'b0, 100);
    apb(8'h00, 1'b1, 32'h01010404);
    wait_lock(1'b1, 400);
    apb(8'h04, 1'b1, 32'h04040C04);
    apb(8'h08, 1'b1, 32'h00000204);
    wait_lock(1'b0, 300);
    apb(8'h04, 1'b1, 32'h04040404);
    wait_lock(1'b1, 400);
    $display("test feedback done");
    results;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results;
  end
endmodule // tb_pll_clock_synth_control
bind pll_clock_synth_control pll_clock_synth_control_asserts #(
  .LOCK_PFD(LOCK_PFD), .REF_TIMEOUT(REF_TIMEOUT)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .synth_reset_n(synth_reset_n),
  .out_clock_0(out_clock_0), .out_clock_1(out_clock_1), .lock_indication(lock_indication));
